// ==== rtl/simd_alu_pkg.sv ====
// constants and operation codes for the packed integer vector datapath
package simd_alu_pkg;

  localparam int          VEC_W        = 128;
  localparam int          GPR_W        = 64;
  localparam int          STR_BYTES    = 16;
  localparam logic [4:0]  STR_NONE_IDX = 5'h10;
  localparam logic [1:0]  RND_NEAREST  = 2'h0;
  localparam logic [1:0]  RND_DOWN     = 2'h1;
  localparam logic [1:0]  RND_UP       = 2'h2;
  localparam logic [1:0]  RND_TRUNC    = 2'h3;
  localparam logic [15:0] WORD_MAX     = 16'hffff;
  localparam int          HMIN_IDX_POS = 16;
  localparam int          LEN_B_POS    = 32;
  localparam logic [127:0] VEC_RST     = 128'h0;
  localparam logic [63:0]  GPR_RST     = 64'h0;

  typedef enum logic [5:0] {
    min_unsigned_word = 6'h00, min_unsigned_dword = 6'h01, min_signed_byte = 6'h02, min_signed_dword = 6'h03,
    max_unsigned_word = 6'h04, max_unsigned_dword = 6'h05, max_signed_byte = 6'h06, max_signed_dword = 6'h07,
    round_vector_single = 6'h08, round_vector_double = 6'h09, round_scalar_single = 6'h0a,
    round_scalar_double = 6'h0b, extract_single_float = 6'h0c, insert_single_float = 6'h0d,
    insert_byte_lane = 6'h0e, insert_dword_lane = 6'h0f, insert_qword_lane = 6'h10,
    extract_byte_lane = 6'h11, extract_word_lane = 6'h12, extract_dword_lane = 6'h13, extract_qword_lane = 6'h14,
    sign_widen_byte_to_word = 6'h15, zero_widen_byte_to_word = 6'h16, sign_widen_byte_to_dword = 6'h17,
    zero_widen_byte_to_dword = 6'h18, sign_widen_word_to_dword = 6'h19, zero_widen_word_to_dword = 6'h1a,
    sign_widen_byte_to_qword = 6'h1b, zero_widen_byte_to_qword = 6'h1c, sign_widen_word_to_qword = 6'h1d,
    zero_widen_word_to_qword = 6'h1e, sign_widen_dword_to_qword = 6'h1f, zero_widen_dword_to_qword = 6'h20,
    multi_block_abs_diff_sum = 6'h21, horizontal_min_search = 6'h22, masked_vector_test = 6'h23,
    qword_equality_compare = 6'h24, saturating_narrow_pack = 6'h25, explicit_string_index_compare = 6'h26,
    explicit_string_mask_compare = 6'h27, implicit_string_index_compare = 6'h28,
    implicit_string_mask_compare = 6'h29, qword_greater_compare = 6'h2a, set_bit_count = 6'h2b
  } op_t;

endpackage

// ==== rtl/fp_round_lane.sv ====
// one floating-point lane rounded to an integral value, still in float format
module fp_round_lane
  import simd_alu_pkg::*;
#(
  parameter int W = 32,
  parameter int E = 8,
  parameter int M = 23
)(
  input  wire logic [W-1:0] lane_in,
  input  wire logic [1:0]   mode,
  output logic      [W-1:0] lane_out
);

  localparam int BIAS = (1 << (E - 1)) - 1;

  logic         sgn;
  logic         nz;
  logic         frac_nz;
  logic         inc;
  logic         to_one;
  logic [W-1:0] frac_m;
  int           unb;
  int           sh;

  always_comb
  begin
    sgn     = lane_in[W-1];
    nz      = |lane_in[W-2:0];
    unb     = int'(lane_in[W-2:M]) - BIAS;
    sh      = 1;
    frac_m  = '0;
    frac_nz = 1'b0;
    inc     = 1'b0;
    to_one  = 1'b0;
    lane_out = lane_in;
    if (unb >= M)
    begin
      // already integral, infinite or not a number
      lane_out = lane_in;
    end
    else if (unb >= 0)
    begin
      sh      = M - unb;
      frac_m  = (W'(1) << sh) - W'(1);
      frac_nz = |(lane_in & frac_m);
      // lane_in[sh] at sh == M is the exponent's low bit, which is 1 for an odd bias: the implied one
      case (mode)
        RND_NEAREST: inc = lane_in[sh-1] & ((|(lane_in & (frac_m >> 1))) | lane_in[sh]);
        RND_DOWN:    inc = sgn & frac_nz;
        RND_UP:      inc = ~sgn & frac_nz;
        default:     inc = 1'b0;
      endcase
      // a carry out of the mantissa bumps the exponent, which is the right answer
      lane_out = (lane_in & ~frac_m) + (inc ? (W'(1) << sh) : W'(0));
    end
    else
    begin
      case (mode)
        RND_NEAREST: to_one = (unb == -1) && (|lane_in[M-1:0]);
        RND_DOWN:    to_one = sgn & nz;
        RND_UP:      to_one = ~sgn & nz;
        default:     to_one = 1'b0;
      endcase
      lane_out = to_one ? {sgn, E'(BIAS), M'(0)} : {sgn, (W-1)'(0)};
    end
  end

endmodule

// ==== rtl/simd_alu.sv ====
// packed integer vector datapath with one-cycle registered results
module simd_alu
  import simd_alu_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       op_valid,
  input  wire simd_alu_pkg::op_t          op_code,
  input  wire logic [simd_alu_pkg::VEC_W-1:0] src_a,
  input  wire logic [simd_alu_pkg::VEC_W-1:0] src_b,
  input  wire logic [simd_alu_pkg::GPR_W-1:0] gpr_in,
  input  wire logic                       src_is_mem,
  input  wire logic [7:0]                 imm,
  output logic                            result_valid_q,
  output logic [simd_alu_pkg::VEC_W-1:0]  result_vec_q,
  output logic [simd_alu_pkg::GPR_W-1:0]  result_gpr_q,
  output logic                            vector_wr_q,
  output logic                            gpr_wr_q,
  output logic                            vector_register_zero_wr_q,
  output logic                            count_general_register_wr_q,
  output logic                            flags_wr_q,
  output logic                            zero_result_flag_q,
  output logic                            carry_result_flag_q
);

  import simd_alu_pkg::*;

  logic [127:0] minsb_v;
  logic [127:0] maxsb_v;
  logic [127:0] minuw_v;
  logic [127:0] maxuw_v;
  logic [127:0] minud_v;
  logic [127:0] maxud_v;
  logic [127:0] minsd_v;
  logic [127:0] maxsd_v;
  logic [127:0] eqq_v;
  logic [127:0] gtq_v;
  logic [127:0] pack_v;
  logic [127:0] sad_v;
  logic [127:0] rnd_s_v;
  logic [127:0] rnd_d_v;
  logic [127:0] vec_d;
  logic [63:0]  gpr_d;
  logic         vec_wr_d;
  logic         gpr_wr_d;
  logic         vzero_wr_d;
  logic         count_wr_d;
  logic         flags_wr_d;
  logic         zf_d;
  logic         cf_d;

  function automatic logic [15:0] sat_word(input logic [31:0] v);
    if (v[31])
      return 16'h0;
    else if (v[30:16] != 15'h0)
      return WORD_MAX;
    else
      return v[15:0];
  endfunction

  function automatic logic [15:0] block_sad(input logic [127:0] a, input logic [127:0] b,
                                            input int ia, input int ib);
    logic [15:0] s;
    logic [7:0]  x;
    logic [7:0]  y;
    s = 16'h0;
    for (int k = 0; k < 4; k++)
    begin
      x = a[8*(ia+k) +: 8];
      y = b[8*(ib+k) +: 8];
      s = s + 16'((x > y) ? (x - y) : (y - x));
    end
    return s;
  endfunction

  // source elements sit in the low bytes of s; sw and dw are element widths in bits
  function automatic logic [127:0] widen(input logic [127:0] s, input int sw, input int dw, input logic sx);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
      for (int b = 0; b < 64; b++)
        if ((i < 128 / dw) && (b < dw))
          r[i*dw+b] = (b < sw) ? s[i*sw+b] : (sx & s[i*sw+sw-1]);
    return r;
  endfunction

  function automatic logic [4:0] implicit_len(input logic [127:0] v);
    logic [4:0] n;
    n = STR_NONE_IDX;
    for (int i = STR_BYTES - 1; i >= 0; i--)
      if (v[8*i +: 8] == 8'h0)
        n = 5'(i);
    return n;
  endfunction

  // one loop builds every per-lane min/max and qword compare, pack and block sum
  for (genvar i = 0; i < 16; i++)
  begin : g_lane
    assign minsb_v[8*i +: 8] = ($signed(src_a[8*i +: 8]) < $signed(src_b[8*i +: 8])) ?
                               src_a[8*i +: 8] : src_b[8*i +: 8];
    assign maxsb_v[8*i +: 8] = ($signed(src_a[8*i +: 8]) > $signed(src_b[8*i +: 8])) ?
                               src_a[8*i +: 8] : src_b[8*i +: 8];
    if (i < 8)
    begin : g_word
      assign minuw_v[16*i +: 16] = (src_a[16*i +: 16] < src_b[16*i +: 16]) ? src_a[16*i +: 16] : src_b[16*i +: 16];
      assign maxuw_v[16*i +: 16] = (src_a[16*i +: 16] > src_b[16*i +: 16]) ? src_a[16*i +: 16] : src_b[16*i +: 16];
      assign sad_v[16*i +: 16]   = block_sad(src_a, src_b, 4 * int'(imm[2]) + i, 4 * int'(imm[1:0]));
    end
    if (i < 4)
    begin : g_dword
      assign minud_v[32*i +: 32] = (src_a[32*i +: 32] < src_b[32*i +: 32]) ? src_a[32*i +: 32] : src_b[32*i +: 32];
      assign maxud_v[32*i +: 32] = (src_a[32*i +: 32] > src_b[32*i +: 32]) ? src_a[32*i +: 32] : src_b[32*i +: 32];
      assign minsd_v[32*i +: 32] = ($signed(src_a[32*i +: 32]) < $signed(src_b[32*i +: 32])) ?
                                   src_a[32*i +: 32] : src_b[32*i +: 32];
      assign maxsd_v[32*i +: 32] = ($signed(src_a[32*i +: 32]) > $signed(src_b[32*i +: 32])) ?
                                   src_a[32*i +: 32] : src_b[32*i +: 32];
      assign pack_v[16*i +: 16]      = sat_word(src_a[32*i +: 32]);
      assign pack_v[64+16*i +: 16]   = sat_word(src_b[32*i +: 32]);
      fp_round_lane #(.W(32), .E(8), .M(23)) u_rnd_s (
        .lane_in  (src_b[32*i +: 32]),
        .mode     (imm[1:0]),
        .lane_out (rnd_s_v[32*i +: 32])
      );
    end
    if (i < 2)
    begin : g_qword
      assign eqq_v[64*i +: 64] = {64{src_a[64*i +: 64] == src_b[64*i +: 64]}};
      assign gtq_v[64*i +: 64] = {64{$signed(src_a[64*i +: 64]) > $signed(src_b[64*i +: 64])}};
      fp_round_lane #(.W(64), .E(11), .M(52)) u_rnd_d (
        .lane_in  (src_b[64*i +: 64]),
        .mode     (imm[1:0]),
        .lane_out (rnd_d_v[64*i +: 64])
      );
    end
  end

  always_comb
  begin
    logic [15:0]  hmin;
    logic [2:0]   hidx;
    logic [31:0]  fval;
    logic [4:0]   len_a;
    logic [4:0]   len_b;
    logic [15:0]  eq_mask;
    logic [4:0]   str_idx;
    hmin       = WORD_MAX;
    hidx       = 3'h0;
    fval       = 32'h0;
    len_a      = 5'h0;
    len_b      = 5'h0;
    eq_mask    = 16'h0;
    str_idx    = STR_NONE_IDX;
    vec_d      = src_a;
    gpr_d      = GPR_RST;
    vec_wr_d   = 1'b1;
    gpr_wr_d   = 1'b0;
    vzero_wr_d = 1'b0;
    count_wr_d = 1'b0;
    flags_wr_d = 1'b0;
    zf_d       = 1'b0;
    cf_d       = 1'b0;
    case (op_code)
      min_signed_byte:     vec_d = minsb_v;
      max_signed_byte:     vec_d = maxsb_v;
      min_unsigned_word:   vec_d = minuw_v;
      max_unsigned_word:   vec_d = maxuw_v;
      min_unsigned_dword:  vec_d = minud_v;
      max_unsigned_dword:  vec_d = maxud_v;
      min_signed_dword:    vec_d = minsd_v;
      max_signed_dword:    vec_d = maxsd_v;
      round_vector_single: vec_d = rnd_s_v;
      round_vector_double: vec_d = rnd_d_v;
      round_scalar_single: vec_d[31:0] = rnd_s_v[31:0];
      round_scalar_double: vec_d[63:0] = rnd_d_v[63:0];
      extract_single_float:
      begin
        vec_wr_d = 1'b0;
        gpr_wr_d = 1'b1;
        gpr_d    = {32'h0, src_b[32*imm[1:0] +: 32]};
      end
      insert_single_float:
      begin
        fval = src_is_mem ? gpr_in[31:0] : src_b[32*imm[7:6] +: 32];
        vec_d[32*imm[5:4] +: 32] = fval;
        for (int i = 0; i < 4; i++)
          if (imm[i])
            vec_d[32*i +: 32] = 32'h0;
      end
      insert_byte_lane:   vec_d[8*imm[3:0] +: 8]   = gpr_in[7:0];
      insert_dword_lane:  vec_d[32*imm[1:0] +: 32] = gpr_in[31:0];
      insert_qword_lane:  vec_d[64*imm[0] +: 64]   = gpr_in;
      extract_byte_lane, extract_word_lane, extract_dword_lane, extract_qword_lane:
      begin
        vec_wr_d = 1'b0;
        gpr_wr_d = 1'b1;
        case (op_code)
          extract_byte_lane:  gpr_d = {56'h0, src_b[8*imm[3:0] +: 8]};
          extract_word_lane:  gpr_d = {48'h0, src_b[16*imm[2:0] +: 16]};
          extract_dword_lane: gpr_d = {32'h0, src_b[32*imm[1:0] +: 32]};
          default:            gpr_d = src_b[64*imm[0] +: 64];
        endcase
      end
      sign_widen_byte_to_word:   vec_d = widen(src_b, 8, 16, 1'b1);
      sign_widen_byte_to_dword:  vec_d = widen(src_b, 8, 32, 1'b1);
      sign_widen_word_to_dword:  vec_d = widen(src_b, 16, 32, 1'b1);
      sign_widen_byte_to_qword:  vec_d = widen(src_b, 8, 64, 1'b1);
      sign_widen_word_to_qword:  vec_d = widen(src_b, 16, 64, 1'b1);
      sign_widen_dword_to_qword: vec_d = widen(src_b, 32, 64, 1'b1);
      zero_widen_byte_to_word:   vec_d = widen(src_b, 8, 16, 1'b0);
      zero_widen_byte_to_dword:  vec_d = widen(src_b, 8, 32, 1'b0);
      zero_widen_word_to_dword:  vec_d = widen(src_b, 16, 32, 1'b0);
      zero_widen_byte_to_qword:  vec_d = widen(src_b, 8, 64, 1'b0);
      zero_widen_word_to_qword:  vec_d = widen(src_b, 16, 64, 1'b0);
      zero_widen_dword_to_qword: vec_d = widen(src_b, 32, 64, 1'b0);
      multi_block_abs_diff_sum:  vec_d = sad_v;
      horizontal_min_search:
      begin
        // scan from the top with <= so the lowest index wins a tie
        for (int i = 7; i >= 0; i--)
          if (src_b[16*i +: 16] <= hmin)
          begin
            hmin = src_b[16*i +: 16];
            hidx = 3'(i);
          end
        vec_d = {96'h0, 13'h0, hidx, hmin};
      end
      masked_vector_test:
      begin
        vec_wr_d   = 1'b0;
        flags_wr_d = 1'b1;
        zf_d       = ~|(src_a & src_b);
        cf_d       = ~|(~src_b & src_a);
      end
      qword_equality_compare: vec_d = eqq_v;
      qword_greater_compare:  vec_d = gtq_v;
      saturating_narrow_pack: vec_d = pack_v;
      set_bit_count:
      begin
        vec_wr_d   = 1'b0;
        gpr_wr_d   = 1'b1;
        flags_wr_d = 1'b1;
        gpr_d      = 64'($countones(gpr_in));
        zf_d       = (gpr_in == GPR_RST);
      end
      explicit_string_index_compare, explicit_string_mask_compare,
      implicit_string_index_compare, implicit_string_mask_compare:
      begin
        // only equal-each byte matching is carried; other aggregation modes are not modelled
        if (op_code == explicit_string_index_compare || op_code == explicit_string_mask_compare)
        begin
          len_a = (gpr_in[4:0] > STR_NONE_IDX) ? STR_NONE_IDX : gpr_in[4:0];
          len_b = (gpr_in[LEN_B_POS +: 5] > STR_NONE_IDX) ? STR_NONE_IDX : gpr_in[LEN_B_POS +: 5];
        end
        else
        begin
          len_a = implicit_len(src_a);
          len_b = implicit_len(src_b);
        end
        for (int i = 0; i < STR_BYTES; i++)
          eq_mask[i] = ((5'(i) < len_a) && (5'(i) < len_b)) ? (src_a[8*i +: 8] == src_b[8*i +: 8]) :
                       ((5'(i) >= len_a) && (5'(i) >= len_b));
        for (int i = STR_BYTES - 1; i >= 0; i--)
          if (eq_mask[i] && (str_idx == STR_NONE_IDX || !imm[6]))
            str_idx = 5'(i);
        vec_wr_d   = 1'b0;
        flags_wr_d = 1'b1;
        cf_d       = |eq_mask;
        zf_d       = (len_b < STR_NONE_IDX);
        if (op_code == explicit_string_index_compare || op_code == implicit_string_index_compare)
        begin
          count_wr_d = 1'b1;
          gpr_d      = {59'h0, str_idx};
        end
        else
        begin
          vzero_wr_d = 1'b1;
          vec_d      = {112'h0, eq_mask};
          if (imm[6])
            for (int i = 0; i < STR_BYTES; i++)
              vec_d[8*i +: 8] = {8{eq_mask[i]}};
        end
      end
      default: vec_wr_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      result_valid_q              <= 1'b0;
      vector_wr_q                 <= 1'b0;
      gpr_wr_q                    <= 1'b0;
      vector_register_zero_wr_q   <= 1'b0;
      count_general_register_wr_q <= 1'b0;
      flags_wr_q                  <= 1'b0;
    end
    else
    begin
      result_valid_q              <= op_valid;
      vector_wr_q                 <= op_valid & vec_wr_d;
      gpr_wr_q                    <= op_valid & gpr_wr_d;
      vector_register_zero_wr_q   <= op_valid & vzero_wr_d;
      count_general_register_wr_q <= op_valid & count_wr_d;
      flags_wr_q                  <= op_valid & flags_wr_d;
    end
  end

  // data registers hold their last value while no operation is issued
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      result_vec_q        <= VEC_RST;
      result_gpr_q        <= GPR_RST;
      zero_result_flag_q  <= 1'b0;
      carry_result_flag_q <= 1'b0;
    end
    else if (op_valid)
    begin
      result_vec_q        <= vec_d;
      result_gpr_q        <= gpr_d;
      zero_result_flag_q  <= zf_d;
      carry_result_flag_q <= cf_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_min_signed_byte: assert property (op_valid && op_code == min_signed_byte |=>
    result_vec_q[127:120] == (($signed($past(src_a[127:120])) < $signed($past(src_b[127:120]))) ?
    $past(src_a[127:120]) : $past(src_b[127:120]))) else $error("signed byte min lane wrong");
  a_max_unsigned_dword: assert property (op_valid && op_code == max_unsigned_dword |=>
    result_vec_q[31:0] >= $past(src_a[31:0]) && result_vec_q[31:0] >= $past(src_b[31:0]))
    else $error("unsigned dword max below an operand");
  a_hmin_tie_low: assert property (op_valid && op_code == horizontal_min_search
    && src_b[15:0] == src_b[127:112] && src_b[15:0] == 16'h0 |=> result_vec_q[127:16] == 112'h0)
    else $error("tie did not report lane zero");
  a_hmin_value: assert property (op_valid && op_code == horizontal_min_search |-> ##1
    result_vec_q[15:0] <= $past(src_b[47:32]) && result_vec_q[31:19] == 13'h0)
    else $error("horizontal minimum not minimal");
  a_test_zero_flag: assert property (op_valid && op_code == masked_vector_test |=>
    flags_wr_q && zero_result_flag_q == (($past(src_a) & $past(src_b)) == VEC_RST))
    else $error("zero flag mismatch");
  a_test_carry_flag: assert property (op_valid && op_code == masked_vector_test |=>
    carry_result_flag_q == ((~$past(src_b) & $past(src_a)) == VEC_RST))
    else $error("carry flag mismatch");
  a_qword_equal: assert property (op_valid && op_code == qword_equality_compare && src_a == src_b |=>
    result_vec_q == {128{1'b1}}) else $error("equal qwords not flagged");
  a_qword_greater: assert property (op_valid && op_code == qword_greater_compare |=>
    result_vec_q[127] == ($signed($past(src_a[127:64])) > $signed($past(src_b[127:64]))))
    else $error("qword greater lane wrong");
  a_pack_clamp: assert property (op_valid && op_code == saturating_narrow_pack && src_a[31] |=>
    result_vec_q[15:0] == 16'h0) else $error("negative dword not clamped to zero");
  a_bit_count: assert property (op_valid && op_code == set_bit_count |=>
    gpr_wr_q && result_gpr_q == 64'($countones($past(gpr_in)))) else $error("bit count wrong");
  a_index_route: assert property (op_valid && op_code == implicit_string_index_compare |=>
    count_general_register_wr_q && !vector_register_zero_wr_q && result_gpr_q <= 64'(STR_NONE_IDX))
    else $error("string index misrouted");
  a_mask_route: assert property (op_valid && op_code == explicit_string_mask_compare |=>
    vector_register_zero_wr_q && !count_general_register_wr_q) else $error("string mask misrouted");
  a_sign_widen: assert property (op_valid && op_code == sign_widen_byte_to_word |=>
    result_vec_q[31:16] == {{8{$past(src_b[15])}}, $past(src_b[15:8])}) else $error("sign widen wrong");

endmodule

// ==== testbench/issue_model.sv ====
// issue side model: presents one operation and releases its operands
module issue_model
  import simd_alu_pkg::*;
(
  input  wire logic              clk,
  output logic                   op_valid,
  output simd_alu_pkg::op_t      op_code,
  output logic [127:0]           src_a,
  output logic [127:0]           src_b,
  output logic [63:0]            gpr_in,
  output logic                   src_is_mem,
  output logic [7:0]             imm
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {op_valid, src_a, src_b, gpr_in, src_is_mem, imm} = '0;
    op_code = min_unsigned_word;
  end
  // released operands except imm are inverted so a late sample cannot match
  task automatic issue(input op_t c, input logic [127:0] a, input logic [127:0] b,
                       input logic [63:0] g, input logic [7:0] i, input logic m);
    @(posedge clk);
    op_code <= c;
    {op_valid, src_a, src_b, gpr_in, src_is_mem, imm} <= {1'b1, a, b, g, m, i};
    @(posedge clk);
    {op_valid, src_a, src_b, gpr_in, src_is_mem} <= {1'b0, ~a, ~b, ~g, ~m};
    #1;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the packed integer vector datapath
module testbench;
  import simd_alu_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         op_valid, src_is_mem, rv, vw, gw, zw, cw, fw, zf, cf;
  op_t          op_code;
  logic [127:0] src_a, src_b, rvec;
  logic [63:0]  gpr_in, rgpr;
  logic [7:0]   imm;
  int           mismatches = 0;
  int           checked = 0;
  logic [127:0] a = {16{8'h80}};
  logic [127:0] b = {16{8'h01}};
  logic [127:0] h = 128'h0007_0008_0009_000a_0003_0009_0003_0005;
  always #25 clk = ~clk;
  issue_model issue_model_inst (.clk(clk), .op_valid(op_valid), .op_code(op_code), .src_a(src_a),
    .src_b(src_b), .gpr_in(gpr_in), .src_is_mem(src_is_mem), .imm(imm));
  simd_alu simd_alu_inst (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .src_a(src_a), .src_b(src_b), .gpr_in(gpr_in), .src_is_mem(src_is_mem), .imm(imm),
    .result_valid_q(rv), .result_vec_q(rvec), .result_gpr_q(rgpr), .vector_wr_q(vw), .gpr_wr_q(gw),
    .vector_register_zero_wr_q(zw), .count_general_register_wr_q(cw), .flags_wr_q(fw),
    .zero_result_flag_q(zf), .carry_result_flag_q(cf));
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input op_t c, input logic [127:0] x, input logic [127:0] y, input logic [63:0] g,
                     input logic [7:0] i = 8'h03, input logic m = 1'b0);
    issue_model_inst.issue(c, x, y, g, i, m);
    check(rv, 1'b1);
  endtask
  task automatic min_max;
    op_t ops[8] = '{min_signed_byte, max_signed_byte, min_unsigned_word, max_unsigned_word,
                    min_signed_dword, max_signed_dword, min_unsigned_dword, max_unsigned_dword};
    bit  pick_a[8] = '{1, 0, 0, 1, 1, 0, 0, 1};
    for (int k = 0; k < 8; k++)
    begin
      run(ops[k], a, b, 64'h0);
      check(rvec, pick_a[k] ? a : b);
      check(vw, 1'b1);
    end
  endtask
  task automatic widen;
    run(sign_widen_byte_to_word, '0, a, 64'h0);
    check(rvec, {8{16'hff80}});
    run(zero_widen_byte_to_word, '0, a, 64'h0);
    check(rvec, {8{16'h0080}});
    run(sign_widen_dword_to_qword, '0, a, 64'h0);
    check(rvec, {2{64'hffffffff_80808080}});
  endtask
  task automatic search_and_test;
    run(horizontal_min_search, '0, h, 64'h0);
    check(rvec, 128'h0001_0003);
    run(horizontal_min_search, '0, {16'h0, {6{16'h0042}}, 16'h0}, 64'h0);
    check(rvec, 128'h0);
    run(masked_vector_test, 128'h0f, 128'hf0, 64'h0);
    check({fw, zf, cf}, 3'h6);
    run(masked_vector_test, 128'h0f, 128'hff, 64'h0);
    check({fw, zf, cf}, 3'h5);
  endtask
  task automatic qword_ops;
    run(qword_equality_compare, {64'h5, 64'hffffffff_ffffffff}, {64'h5, 64'h1}, 64'h0);
    check(rvec, {64'hffffffff_ffffffff, 64'h0});
    run(qword_equality_compare, a, a, 64'h0);
    check(rvec, {128{1'b1}});
    run(qword_greater_compare, {64'h5, 64'h1}, {64'h5, 64'hffffffff_ffffffff}, 64'h0);
    check(rvec, {64'h0, 64'hffffffff_ffffffff});
    run(saturating_narrow_pack, 128'h00000000_00012345_00001234_ffffffff, '0, 64'h0);
    check(rvec, 128'h0000_ffff_1234_0000);
  endtask
  task automatic gpr_ops;
    run(set_bit_count, '0, '0, 64'h80000000_000000f1);
    check({gw, rgpr}, {1'b1, 64'h6});
    run(insert_dword_lane, '0, '0, 64'h11223344_aabbccdd);
    check(rvec, {32'haabbccdd, 96'h0});
    run(extract_word_lane, '0, h, 64'h0);
    check(rgpr, 64'h3);
  endtask
  task automatic round_and_float;
    logic [127:0] f = 128'hbfc00000_40200000_3fc00000_3f400000;
    logic [127:0] d = 128'h44444444_33333333_22222222_11111111;
    run(round_vector_single, '0, f, 64'h0, 8'h00);
    check(rvec, 128'hc0000000_40000000_40000000_3f800000);
    run(round_scalar_double, {64'h1234, 64'h0}, {64'h3ff80000_00000000, 64'h40060000_00000000}, 64'h0);
    check(rvec, {64'h1234, 64'h40000000_00000000});
    run(extract_single_float, '0, f, 64'h0);
    check({vw, gw, rgpr}, {2'h1, 64'hbfc00000});
    run(insert_single_float, d, f, 64'h0, 8'h61);
    check(rvec, 128'h44444444_3fc00000_22222222_00000000);
    run(insert_single_float, d, f, 64'h40490fdb, 8'h08, 1'b1);
    check(rvec, 128'h00000000_33333333_22222222_40490fdb);
  endtask
  task automatic block_sums;
    run(multi_block_abs_diff_sum, 128'h0f0e0d0c_0b0a0908_07060504_03020100, {32'h01010101, {12{8'hff}}}, 64'h0);
    check(rvec, 128'h001e_001a_0016_0012_000e_000a_0006_0004);
  endtask
  task automatic strings;
    logic [127:0] s = 128'h00636261;
    logic [127:0] t = 128'h00636278;
    run(implicit_string_index_compare, s, t, 64'h0, 8'h00);
    check({cw, zw, fw, zf, cf, rgpr}, {5'h17, 64'h1});
    run(explicit_string_index_compare, s, t, 64'h00000002_00000002, 8'h40);
    check({cw, zw, rgpr}, {2'h2, 64'hf});
    run(explicit_string_mask_compare, s, t, 64'h00000002_00000002, 8'h00);
    check({zw, cw, vw}, 3'h4);
    check(rvec, 128'hfffe);
    run(implicit_string_mask_compare, s, t, 64'h0, 8'h40);
    check({zw, cw}, 2'h2);
    check(rvec, {{15{8'hff}}, 8'h00});
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    min_max();
    widen();
    search_and_test();
    qword_ops();
    gpr_ops();
    round_and_float();
    block_sums();
    strings();
    end_of_test();
  end
  initial
  begin
    #200000;
    mismatches++;
    end_of_test();
  end
endmodule
